// File: logic/cpu_ctl_pkg.sv
package cpu_ctl_pkg;
    // Bus clock runs at 10 MHz.
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CFG_W = 8;
    // Output release deadline after reset is seen, in bus clocks.
    localparam int unsigned RST_RELEASE_CLKS = 2;
    // Cycles the save step takes before the acknowledge transaction.
    localparam logic [3:0] SAVE_CYCLES = 4'h4;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    // Bus transaction codes presented on the acknowledge port.
    localparam logic [1:0] TXN_NONE = 2'h0;
    localparam logic [1:0] TXN_SMI_ACK = 2'h1;
    localparam logic [1:0] TXN_GRANT_ACK = 2'h2;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
    // Output register after reset: only the cache-invalidate bit is set.
    localparam logic [7:0] OUT_RESET = 8'h04;
    localparam logic [3:0] SYNC_RESET = 4'h0;

    typedef enum logic [5:0] {
        ST_RESET = 6'b00_0001,
        ST_RUN = 6'b00_0010,
        ST_MGMT_SAVE = 6'b00_0100,
        ST_MGMT_RUN = 6'b00_1000,
        ST_GRANT = 6'b01_0000,
        ST_FLOAT = 6'b10_0000
    } core_state_t;
endpackage

// File: logic/sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries synchronised control levels from the input stage to the core.
interface sync_if;
    logic power_ok;
    logic rst_active;
    logic mgmt_req;
    logic halt_req;
    modport src (output power_ok, rst_active, mgmt_req, halt_req);
    modport dst (input power_ok, rst_active, mgmt_req, halt_req);
endinterface
`default_nettype wire

// File: logic/ctl_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchronisers for every asynchronous control pin.
module ctl_sync (
    input wire logic clk_i, // bus clock
    input wire logic nrst_i, // async reset, active low
    input wire logic [3:0] pins_i, // power_ok, rst_n, mgmt_n, halt_n
    sync_if.src out // synchronised, active-high levels
);
    logic [3:0] meta_ff;
    logic [3:0] stab_ff;
    logic [3:0] nxt_meta;
    logic [3:0] nxt_stab;

    always_comb
    begin
        nxt_meta = pins_i;
        nxt_stab = meta_ff;
    end

    // Resets to all zeros: power not ok, and reset, management and halt requests all read asserted.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_ff <= cpu_ctl_pkg::SYNC_RESET;
            stab_ff <= cpu_ctl_pkg::SYNC_RESET;
        end
        else
        begin
            meta_ff <= nxt_meta;
            stab_ff <= nxt_stab;
        end
    end

    assign out.power_ok = stab_ff[3];
    assign out.rst_active = !stab_ff[2];
    assign out.mgmt_req = !stab_ff[1];
    assign out.halt_req = !stab_ff[0];
endmodule
`default_nettype wire

// File: logic/cpu_reset_power_control.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_reset_power_control (
    input wire logic clk_i, // bus clock, 10 MHz
    input wire logic nrst_i, // async reset, active low
    input wire logic power_ok_in, // supplies good, async
    input wire logic sys_rst_n_i, // system reset pin, active low
    input wire logic sys_mgmt_irq_n, // management interrupt, active low
    input wire logic clock_halt_req_n, // clock-halt request, active low
    input wire logic [7:0] cfg_bus_i, // bus levels sampled at reset release
    output logic [7:0] cfg_latched_o, // captured power-on configuration
    output logic bus_drive_o, // bus outputs may be active
    output logic bus_float_o, // all outputs held high-impedance
    output logic [1:0] bus_txn_o, // acknowledge transaction code
    output logic bus_txn_valid_o, // one-cycle transaction strobe
    output logic cache_inval_o, // invalidate caches, no write-back
    output logic state_save_o, // one-cycle save-state pulse
    output logic sys_mgmt_state_o, // management mode active
    output logic grant_o, // low-power grant state active
    output logic core_clk_en_o, // core unit clock enable
    output logic snoop_en_o, // snoop and bus interface enabled
    output logic local_irq_ctrl_en_o, // local interrupt unit running
    output logic exec_en_o // instruction execution enabled
);
    ////////////////////////////////////////////////////////////////////////
    sync_if s ();

    // Every pin passes two flops; halt is async to the bus clock.
    ctl_sync u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pins_i({power_ok_in, sys_rst_n_i, sys_mgmt_irq_n,
                 clock_halt_req_n}),
        .out(s)
    );

    // The config bus is sampled on the same synchronised timeline.
    logic [7:0] cfg_m_ff;
    logic [7:0] cfg_s_ff;
    logic [7:0] nxt_cfg_m;
    logic [7:0] nxt_cfg_s;

    always_comb
    begin
        nxt_cfg_m = cfg_bus_i;
        nxt_cfg_s = cfg_m_ff;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cfg_m_ff <= cpu_ctl_pkg::CFG_RESET;
            cfg_s_ff <= cpu_ctl_pkg::CFG_RESET;
        end
        else
        begin
            cfg_m_ff <= nxt_cfg_m;
            cfg_s_ff <= nxt_cfg_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    cpu_ctl_pkg::core_state_t state_ff;
    cpu_ctl_pkg::core_state_t nxt_state;
    logic rst_seen_ff;
    logic nxt_rst_seen;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [7:0] cfg_ff;
    logic [7:0] nxt_cfg;
    logic [1:0] txn_ff;
    logic [1:0] nxt_txn;
    logic txn_v_ff;
    logic nxt_txn_v;
    logic save_ff;
    logic nxt_save;
    logic release_evt;

    // Reset release is seen as the falling edge of the synchronised level.
    assign release_evt = rst_seen_ff && !s.rst_active;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_rst_seen = s.rst_active;
        nxt_cnt = cnt_ff;
        nxt_cfg = cfg_ff;
        nxt_txn = cpu_ctl_pkg::TXN_NONE;
        nxt_txn_v = 1'b0;
        nxt_save = 1'b0;
        if (s.rst_active || !s.power_ok)
        begin
            // Reset wins over every other state in the cycle it is seen.
            nxt_state = cpu_ctl_pkg::ST_RESET;
        end
        else
        begin
            case (state_ff)
                cpu_ctl_pkg::ST_RESET:
                begin
                    if (release_evt)
                    begin
                        nxt_cfg = cfg_s_ff;
                        if (s.mgmt_req)
                        begin
                            nxt_state = cpu_ctl_pkg::ST_FLOAT;
                        end
                        else
                        begin
                            nxt_state = cpu_ctl_pkg::ST_RUN;
                        end
                    end
                end
                cpu_ctl_pkg::ST_RUN:
                begin
                    // Management interrupts take priority over a halt.
                    if (s.mgmt_req)
                    begin
                        nxt_state = cpu_ctl_pkg::ST_MGMT_SAVE;
                        nxt_save = 1'b1;
                        nxt_cnt = cpu_ctl_pkg::SAVE_CYCLES;
                    end
                    else if (s.halt_req)
                    begin
                        nxt_state = cpu_ctl_pkg::ST_GRANT;
                        nxt_txn = cpu_ctl_pkg::TXN_GRANT_ACK;
                        nxt_txn_v = 1'b1;
                    end
                end
                cpu_ctl_pkg::ST_MGMT_SAVE:
                begin
                    if (cnt_ff == cpu_ctl_pkg::CNT_ONE)
                    begin
                        nxt_state = cpu_ctl_pkg::ST_MGMT_RUN;
                        nxt_txn = cpu_ctl_pkg::TXN_SMI_ACK;
                        nxt_txn_v = 1'b1;
                    end
                    nxt_cnt = cnt_ff - cpu_ctl_pkg::CNT_ONE;
                end
                cpu_ctl_pkg::ST_MGMT_RUN:
                begin
                    // Handler returns when the request is withdrawn.
                    if (!s.mgmt_req)
                    begin
                        nxt_state = cpu_ctl_pkg::ST_RUN;
                    end
                end
                cpu_ctl_pkg::ST_GRANT:
                begin
                    if (!s.halt_req)
                    begin
                        nxt_state = cpu_ctl_pkg::ST_RUN;
                    end
                end
                cpu_ctl_pkg::ST_FLOAT:
                begin
                    // Only a new reset or loss of power leaves the floated state.
                    nxt_state = cpu_ctl_pkg::ST_FLOAT;
                end
                default:
                begin
                    nxt_state = cpu_ctl_pkg::ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_ff <= cpu_ctl_pkg::ST_RESET;
            rst_seen_ff <= 1'b1;
            cnt_ff <= cpu_ctl_pkg::CNT_ZERO;
            cfg_ff <= cpu_ctl_pkg::CFG_RESET;
            txn_ff <= cpu_ctl_pkg::TXN_NONE;
            txn_v_ff <= 1'b0;
            save_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            rst_seen_ff <= nxt_rst_seen;
            cnt_ff <= nxt_cnt;
            cfg_ff <= nxt_cfg;
            txn_ff <= nxt_txn;
            txn_v_ff <= nxt_txn_v;
            save_ff <= nxt_save;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs are decoded from the next state, so the registered copy
    // changes on the same edge as the state register and stays flop-driven.
    logic [7:0] out_ff;
    logic [7:0] nxt_out;
    logic in_rst;
    logic in_grant;

    assign in_rst = (nxt_state == cpu_ctl_pkg::ST_RESET);
    assign in_grant = (nxt_state == cpu_ctl_pkg::ST_GRANT);

    always_comb
    begin
        nxt_out[0] = !in_rst && (nxt_state != cpu_ctl_pkg::ST_FLOAT);
        nxt_out[1] = (nxt_state == cpu_ctl_pkg::ST_FLOAT);
        nxt_out[2] = in_rst;
        nxt_out[3] = (nxt_state == cpu_ctl_pkg::ST_MGMT_SAVE)
                  || (nxt_state == cpu_ctl_pkg::ST_MGMT_RUN);
        nxt_out[4] = in_grant;
        nxt_out[5] = nxt_out[0] && !in_grant;
        // Snoop and local interrupt logic keep running in grant.
        nxt_out[6] = nxt_out[0];
        nxt_out[7] = nxt_out[5] && (nxt_state != cpu_ctl_pkg::ST_MGMT_SAVE);
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            out_ff <= cpu_ctl_pkg::OUT_RESET;
        end
        else
        begin
            out_ff <= nxt_out;
        end
    end

    assign bus_drive_o = out_ff[0];
    assign bus_float_o = out_ff[1];
    assign cache_inval_o = out_ff[2];
    assign sys_mgmt_state_o = out_ff[3];
    assign grant_o = out_ff[4];
    assign core_clk_en_o = out_ff[5];
    assign snoop_en_o = out_ff[6];
    assign local_irq_ctrl_en_o = out_ff[6];
    assign exec_en_o = out_ff[7];
    assign cfg_latched_o = cfg_ff;
    assign bus_txn_o = txn_ff;
    assign bus_txn_valid_o = txn_v_ff;
    assign state_save_o = save_ff;
endmodule
`default_nettype wire

// File: tb/cpu_ctl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_ctl_sva (
    input wire logic clk_i, // bus clock
    input wire logic nrst_i, // reset, active low
    input wire logic sys_rst_n_i, // system reset pin
    input wire logic clock_halt_req_n, // halt pin
    input wire logic [7:0] cfg_latched_o, // captured straps
    input wire logic bus_drive_o, // bus active
    input wire logic bus_float_o, // outputs floated
    input wire logic [1:0] bus_txn_o, // transaction code
    input wire logic bus_txn_valid_o, // transaction strobe
    input wire logic cache_inval_o, // cache invalidate
    input wire logic state_save_o, // save pulse
    input wire logic grant_o, // grant state
    input wire logic core_clk_en_o, // core clocks
    input wire logic snoop_en_o, // snooping on
    input wire logic local_irq_ctrl_en_o, // interrupt unit on
    input wire logic exec_en_o // execution on
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Three edges: two synchroniser stages plus the output register.
    rst_release_a: assert property (
        $fell(sys_rst_n_i) |-> ##[1:3] !bus_drive_o)
        else $error("bus still driven after reset");
    inval_quiet_a: assert property (
        cache_inval_o |-> !bus_drive_o && !exec_en_o && !bus_txn_valid_o)
        else $error("activity while caches are invalidated");
    cfg_hold_a: assert property (
        bus_drive_o && $past(bus_drive_o) |-> $stable(cfg_latched_o))
        else $error("configuration changed outside reset release");
    // A reset seen during the save step legally cuts the acknowledge.
    save_ack_a: assert property (
        state_save_o |-> ##4 (cache_inval_o || (bus_txn_valid_o
            && bus_txn_o == cpu_ctl_pkg::TXN_SMI_ACK)))
        else $error("management acknowledge missing");
    strobe_once_a: assert property (
        bus_txn_valid_o |-> bus_txn_o != cpu_ctl_pkg::TXN_NONE
            ##1 !bus_txn_valid_o)
        else $error("bad transaction strobe");
    float_hold_a: assert property (
        bus_float_o |-> !bus_drive_o && !bus_txn_valid_o
            ##1 (bus_float_o || cache_inval_o))
        else $error("floated state broken");
    grant_ack_a: assert property (
        $rose(grant_o) |-> bus_txn_valid_o
            && bus_txn_o == cpu_ctl_pkg::TXN_GRANT_ACK)
        else $error("grant entered without acknowledge");
    grant_clk_a: assert property (
        grant_o |-> !core_clk_en_o && snoop_en_o && local_irq_ctrl_en_o)
        else $error("wrong clocking in grant state");
    resume_run_a: assert property (
        $rose(clock_halt_req_n) && grant_o |-> ##[1:3]
            (core_clk_en_o && exec_en_o && !grant_o))
        else $error("no resume after halt release");
    halt_sync_a: assert property (
        $fell(clock_halt_req_n) |-> !grant_o ##1 !grant_o)
        else $error("halt acted on before synchronising");

    grant_c: cover property ($rose(grant_o));
    save_c: cover property (state_save_o);
    float_c: cover property ($rose(bus_float_o));
endmodule

bind cpu_reset_power_control cpu_ctl_sva u_sva (.clk_i, .nrst_i,
    .sys_rst_n_i, .clock_halt_req_n, .cfg_latched_o, .bus_drive_o,
    .bus_float_o, .bus_txn_o, .bus_txn_valid_o, .cache_inval_o,
    .state_save_o, .grant_o, .core_clk_en_o, .snoop_en_o,
    .local_irq_ctrl_en_o, .exec_en_o);
`default_nettype wire

// File: tb/board_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Reset pulse is shortened from milliseconds to keep the run short.
module board_ctl_model #(parameter int RST_CLKS = 20) (
    input wire logic clk_i, // bus clock
    output var logic power_ok_o, // supplies good
    output var logic sys_rst_n_o, // system reset
    output var logic mgmt_n_o, // management request
    output var logic halt_n_o, // halt request
    output var logic [7:0] cfg_o // strap levels
);
    initial
    begin
        power_ok_o = 1'b0;
        sys_rst_n_o = 1'b0;
        mgmt_n_o = 1'b1;
        halt_n_o = 1'b1;
        cfg_o = 8'h00;
    end

    // Straps are flipped soon after release so a late capture is seen.
    task automatic reset_pulse(input logic [7:0] cfg);
        @(posedge clk_i);
        sys_rst_n_o <= 1'b0;
        cfg_o <= cfg;
        repeat (RST_CLKS) @(posedge clk_i);
        sys_rst_n_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        cfg_o <= ~cfg;
    endtask

    task automatic power_up(input logic [7:0] cfg);
        @(posedge clk_i);
        power_ok_o <= 1'b1;
        reset_pulse(cfg);
    endtask

    // Supplies fail; a new power_up must follow before normal running.
    task automatic power_drop();
        @(posedge clk_i);
        power_ok_o <= 1'b0;
    endtask

    task automatic drive(input logic mgmt_n, input logic halt_n);
        @(posedge clk_i);
        mgmt_n_o <= mgmt_n;
        halt_n_o <= halt_n;
    endtask
endmodule
`default_nettype wire

// File: tb/tb_cpu_reset_power_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_reset_power_control;
    logic clk_i, nrst_i, power_ok_in, sys_rst_n_i;
    logic sys_mgmt_irq_n, clock_halt_req_n;
    logic [7:0] cfg_bus_i, cfg_latched_o;
    logic [1:0] bus_txn_o;
    logic bus_drive_o, bus_float_o, bus_txn_valid_o, cache_inval_o;
    logic state_save_o, sys_mgmt_state_o, grant_o, core_clk_en_o;
    logic snoop_en_o, local_irq_ctrl_en_o, exec_en_o;
    int error_cnt = 0;
    int checked = 0;

    cpu_reset_power_control u_dut (.clk_i, .nrst_i, .power_ok_in,
        .sys_rst_n_i, .sys_mgmt_irq_n, .clock_halt_req_n, .cfg_bus_i,
        .cfg_latched_o, .bus_drive_o, .bus_float_o, .bus_txn_o,
        .bus_txn_valid_o, .cache_inval_o, .state_save_o,
        .sys_mgmt_state_o, .grant_o, .core_clk_en_o, .snoop_en_o,
        .local_irq_ctrl_en_o, .exec_en_o);
    board_ctl_model u_board (.clk_i, .power_ok_o(power_ok_in),
        .sys_rst_n_o(sys_rst_n_i), .mgmt_n_o(sys_mgmt_irq_n),
        .halt_n_o(clock_halt_req_n), .cfg_o(cfg_bus_i));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return bus_drive_o;
            1: return grant_o;
            2: return state_save_o;
            3: return sys_mgmt_state_o;
            default: return bus_float_o;
        endcase
    endfunction

    // Samples just after the edge so that edge's updates have landed.
    task automatic wait_for(input int k, input logic v);
        int n;
        for (n = 0; n < 40 && pick(k) !== v; n++)
        begin
            @(posedge clk_i);
            #1;
        end
        check(pick(k), v);
    endtask

    task automatic t_power();
        check(cache_inval_o, 1'b1);
        check(bus_drive_o, 1'b0);
        u_board.power_up(8'h5a);
        wait_for(0, 1'b1);
        check(cfg_latched_o, 8'h5a);
        check({cache_inval_o, exec_en_o, core_clk_en_o}, 8'h03);
    endtask

    task automatic t_halt();
        u_board.drive(1'b1, 1'b0);
        wait_for(1, 1'b1);
        check({bus_txn_valid_o, bus_txn_o}, 8'h06);
        check({core_clk_en_o, exec_en_o}, 8'h00);
        check({snoop_en_o, local_irq_ctrl_en_o}, 8'h03);
        u_board.drive(1'b1, 1'b1);
        wait_for(1, 1'b0);
        check({core_clk_en_o, exec_en_o}, 8'h03);
    endtask

    task automatic t_mgmt();
        u_board.drive(1'b0, 1'b1);
        wait_for(2, 1'b1);
        repeat (4) @(posedge clk_i);
        #1;
        check({bus_txn_valid_o, bus_txn_o}, 8'h05);
        check(sys_mgmt_state_o, 1'b1);
        u_board.drive(1'b0, 1'b0);
        repeat (6) @(posedge clk_i);
        #1;
        check(grant_o, 1'b0);
        u_board.drive(1'b1, 1'b1);
        wait_for(3, 1'b0);
    endtask

    task automatic t_rerun();
        u_board.reset_pulse(8'hc3);
        wait_for(0, 1'b1);
        check(cfg_latched_o, 8'hc3);
    endtask

    task automatic t_float();
        u_board.drive(1'b0, 1'b1);
        u_board.reset_pulse(8'h11);
        wait_for(4, 1'b1);
        check(bus_drive_o, 1'b0);
    endtask

    // Losing power must leave the floated state through reset.
    task automatic t_drop();
        u_board.drive(1'b1, 1'b1);
        u_board.power_drop();
        wait_for(4, 1'b0);
        check({bus_drive_o, cache_inval_o}, 8'h01);
        u_board.power_up(8'h3c);
        wait_for(0, 1'b1);
        check(cfg_latched_o, 8'h3c);
    endtask

    task automatic stop_test();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ///////////////////////////////////////////////////////////////////////
    initial
    begin
        nrst_i = 1'b0;
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        #1;
        t_power();
        t_halt();
        t_mgmt();
        t_rerun();
        t_float();
        t_drop();
        stop_test();
    end

    // Every scenario ends within a few hundred cycles.
    initial
    begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
